// >>> hw/trp_pkg.sv
// package: constants and types for the threshold relay with peak hold
package trp_pkg;

   // ***********************************************
   // widths and timing
   // ***********************************************
   localparam int VAL_W = 16;
   localparam int DLY_W = 10;
   localparam longint CLK_HZ = 200000000;
   localparam longint TICK_MS = 100;
   localparam longint TICK_CYCLES = CLK_HZ * TICK_MS / 1000;
   localparam int TICK_CNT_W = 25;
   localparam int MIN_TICKS = 600;
   localparam int HOLD_W = 16;
   localparam int DLY_RESET = 0;
   localparam int TIMER_W = 16;
   localparam int MIN_STEP_TENTHS = 60; // tenth ticks in one tenth of a minute

   // ***********************************************
   // modes
   // ***********************************************
   typedef enum logic [2:0] {
      MODE_INACTIVE,
      MODE_ON_ABOVE,
      MODE_OFF_ABOVE,
      MODE_IN_BAND,
      MODE_OUT_BAND,
      MODE_SERIAL
   } trp_mode_t;

   typedef enum logic [1:0] {
      CRIT_HOLD,
      CRIT_FORCE_ON,
      CRIT_FORCE_OFF
   } trp_crit_t;

   typedef struct packed {
      trp_mode_t mode;
      logic signed [VAL_W-1:0] firstThreshold;
      logic signed [VAL_W-1:0] secondThreshold;
      logic [VAL_W-1:0] hysteresisHalfWidth;
      logic [DLY_W-1:0] assertDelay;
      logic [DLY_W-1:0] releaseDelay;
      logic unitMinutes;
      trp_crit_t criticalAction;
      logic usePeak;
      logic relayFitted;
      logic serialRelayState;
   } trp_relay_cfg_t;

   typedef struct packed {
      logic peakEnable;
      logic [VAL_W-1:0] peakMinAmplitude;
      logic [HOLD_W-1:0] holdTicks;
   } trp_peak_cfg_t;

endpackage

// >>> hw/trp_relay_ctrl.sv
// relay and indicator control with peak hold, hysteresis and delay timers
`timescale 1ns/1ps

// Contract
// - a peak counts only after a rise then a fall of peak_min_amplitude
// - a recognised peak is presented for the hold time
// - a new peak during hold replaces the value and restarts the timer
// - hold expiry without a new peak returns to the live value
// - a setting picks live or held value for the relay decision
// - indicator lights whenever the relay is closed
// - with no relay fitted only the indicator is driven, same logic
// - function selects unused, single threshold, two thresholds or serial
// - single threshold: on-above closes in upper zone, off-above opens there
// - relay changes only after crossing a border and staying past the delay
// - both delays zero switch at once on crossing
// - nonzero assert delay closes only after staying beyond border that long
// - nonzero release delay opens only after that delay since crossing
// - returning inside the border before expiry abandons the transition
// - critical action forces on, forces off or holds under a critical condition
// - two thresholds: inside or outside band closes, other zone opens
// - smaller threshold is lower, larger is upper, in any order
// - one hysteresis, function, delay pair, unit and action for both thresholds
// - inactive function keeps the relay released
// - serial function follows the written state, not kept over power loss
// - delays 0 to 99.9 in 0.1 steps, seconds or minutes
module trp_relay_ctrl
   import trp_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic signed [VAL_W-1:0] inValue,
   input wire logic inValid,
   input wire logic inCritical,
   input wire trp_peak_cfg_t peakCfg,
   input wire trp_relay_cfg_t relayCfg,
   output logic relayDrive,
   output logic indicatorLed,
   output logic signed [VAL_W-1:0] presentedValue,
   output logic peakHolding
);

   // ***********************************************
   // tenth-second time base
   // ***********************************************
   logic [TICK_CNT_W-1:0] tickCnt_reg;
   logic tenthTick_reg;
   logic [5:0] minuteDiv_reg;
   logic minuteTick_reg;

   // tenths of a second from the core clock; free-running, so a timer armed
   // mid-step meets its first step early and every timer counts one step more
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         tickCnt_reg <= '0;
         tenthTick_reg <= 1'b0;
      end else if (tickCnt_reg == TICK_CNT_W'(TICK_CYCLES - 1)) begin
         tickCnt_reg <= '0;
         tenthTick_reg <= 1'b1;
      end else begin
         tickCnt_reg <= tickCnt_reg + 1'b1;
         tenthTick_reg <= 1'b0;
      end
   end

   // tenths of a minute: every 60 tenth ticks
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         minuteDiv_reg <= '0;
         minuteTick_reg <= 1'b0;
      end else if (tenthTick_reg) begin
         minuteTick_reg <= (minuteDiv_reg == 6'(MIN_STEP_TENTHS - 1));
         if (minuteDiv_reg == 6'(MIN_STEP_TENTHS - 1)) begin
            minuteDiv_reg <= '0;
         end else begin
            minuteDiv_reg <= minuteDiv_reg + 1'b1;
         end
      end else begin
         minuteTick_reg <= 1'b0;
      end
   end

   // unit selects the step of both delays
   logic delayStep;
   assign delayStep = relayCfg.unitMinutes ? minuteTick_reg : tenthTick_reg;

   // ***********************************************
   // peak detector
   // ***********************************************
   // running extremes; the rise arms the tracker, the fall fires it
   logic signed [VAL_W-1:0] runMax_reg;
   logic signed [VAL_W-1:0] runMin_reg;
   logic rising_reg;
   logic signed [VAL_W-1:0] heldPeak_reg;
   logic [HOLD_W-1:0] holdCnt_reg;
   logic holding_reg;
   logic peakFound;
   logic signed [VAL_W:0] riseAmt;
   logic signed [VAL_W:0] fallAmt;
   logic signed [VAL_W:0] minAmp;

   assign riseAmt = {inValue[VAL_W-1], inValue} - {runMin_reg[VAL_W-1], runMin_reg};
   assign fallAmt = {runMax_reg[VAL_W-1], runMax_reg} - {inValue[VAL_W-1], inValue};
   assign minAmp = {1'b0, peakCfg.peakMinAmplitude};
   // a peak needs a rise already armed and then a fall of the full amplitude
   assign peakFound = peakCfg.peakEnable && inValid && rising_reg && (fallAmt >= minAmp);

   // track rise from the valley, then fall from the top
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         runMax_reg <= '0;
         runMin_reg <= '0;
         rising_reg <= 1'b0;
      end else if (inValid) begin
         if (!peakCfg.peakEnable) begin
            // restart at the live value so a re-enable never finds a stale rise
            rising_reg <= 1'b0;
            runMin_reg <= inValue;
            runMax_reg <= inValue;
         end else if (peakFound) begin
            rising_reg <= 1'b0;
            runMin_reg <= inValue;
            runMax_reg <= inValue;
         end else if (!rising_reg) begin
            if (inValue < runMin_reg) begin
               runMin_reg <= inValue;
            end
            if (riseAmt >= minAmp) begin
               rising_reg <= 1'b1;
               runMax_reg <= inValue;
            end
         end else if (inValue > runMax_reg) begin
            runMax_reg <= inValue;
         end
      end
   end

   // hold timer; a new peak always restarts it, expiry drops the hold
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         heldPeak_reg <= '0;
         holdCnt_reg <= '0;
         holding_reg <= 1'b0;
      end else if (peakFound) begin
         heldPeak_reg <= runMax_reg;
         holdCnt_reg <= '0;
         holding_reg <= 1'b1;
      end else if (holding_reg && tenthTick_reg) begin
         // one step more than asked, so an early first step never cuts the hold
         if (holdCnt_reg >= peakCfg.holdTicks) begin
            holding_reg <= 1'b0;
         end
         holdCnt_reg <= holdCnt_reg + 1'b1;
      end else if (!peakCfg.peakEnable) begin
         holding_reg <= 1'b0;
      end
   end

   // last live sample, kept while a peak is shown so expiry falls back to it at once
   logic signed [VAL_W-1:0] lastLive_reg;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         lastLive_reg <= '0;
      end else if (inValid) begin
         lastLive_reg <= inValue;
      end
   end

   // holding flag to the pins, one clock behind the timer like the value
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         peakHolding <= 1'b0;
      end else begin
         peakHolding <= holding_reg;
      end
   end

   // presented value: held peak while holding, else the live value
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         presentedValue <= '0;
      end else if (holding_reg) begin
         presentedValue <= heldPeak_reg;
      end else if (inValid) begin
         presentedValue <= inValue;
      end else begin
         presentedValue <= lastLive_reg;
      end
   end

   // ***********************************************
   // zone decision
   // ***********************************************
   // zones use the sample itself, so a decision lands on its own strobe
   logic signed [VAL_W-1:0] lowThr;
   logic signed [VAL_W-1:0] highThr;
   logic signed [VAL_W-1:0] ctrlValue;
   logic signed [VAL_W+1:0] hysteresis_half_width;
   logic inActiveZone;
   logic inPassiveZone;
   logic wantOn;

   // order-free thresholds
   assign lowThr = (relayCfg.firstThreshold < relayCfg.secondThreshold) ?
      relayCfg.firstThreshold : relayCfg.secondThreshold;
   assign highThr = (relayCfg.firstThreshold < relayCfg.secondThreshold) ?
      relayCfg.secondThreshold : relayCfg.firstThreshold;
   // the held peak steers only while it is held; otherwise the live value
   assign ctrlValue = (relayCfg.usePeak && holding_reg) ? heldPeak_reg : inValue;
   assign hysteresis_half_width = {2'b00, relayCfg.hysteresisHalfWidth};

   // strictly beyond a border of threshold +/- hysteresis; both sides are widened
   // and kept signed, or a negative value would compare as a huge one
   function automatic logic above(input logic signed [VAL_W-1:0] v, input logic signed [VAL_W-1:0] t);
      logic signed [VAL_W+1:0] wideV;
      logic signed [VAL_W+1:0] wideT;
      wideV = {{2{v[VAL_W-1]}}, v};
      wideT = {{2{t[VAL_W-1]}}, t};
      above = (wideV > wideT + hysteresis_half_width);
   endfunction

   function automatic logic below(input logic signed [VAL_W-1:0] v, input logic signed [VAL_W-1:0] t);
      logic signed [VAL_W+1:0] wideV;
      logic signed [VAL_W+1:0] wideT;
      wideV = {{2{v[VAL_W-1]}}, v};
      wideT = {{2{t[VAL_W-1]}}, t};
      below = (wideV < wideT - hysteresis_half_width);
   endfunction

   // one hysteresis and one function serve both thresholds
   always_comb begin
      inActiveZone = 1'b0;
      inPassiveZone = 1'b0;
      wantOn = 1'b0;
      unique case (relayCfg.mode)
         MODE_ON_ABOVE, MODE_OFF_ABOVE: begin
            inActiveZone = above(ctrlValue, relayCfg.firstThreshold);
            inPassiveZone = below(ctrlValue, relayCfg.firstThreshold);
            wantOn = (relayCfg.mode == MODE_ON_ABOVE) ? inActiveZone : inPassiveZone;
         end
         MODE_IN_BAND, MODE_OUT_BAND: begin
            inActiveZone = above(ctrlValue, lowThr) && below(ctrlValue, highThr);
            inPassiveZone = below(ctrlValue, lowThr) || above(ctrlValue, highThr);
            wantOn = (relayCfg.mode == MODE_IN_BAND) ? inActiveZone : inPassiveZone;
         end
         default: begin
         end
      endcase
   end

   logic settled;
   assign settled = inActiveZone || inPassiveZone; // beyond some border

   // ***********************************************
   // delay timers and relay state
   // ***********************************************
   // one counter serves both delays; the pending target picks which applies
   logic relay_reg;
   logic pending_reg;
   logic pendTarget_reg;
   logic [TIMER_W-1:0] dlyCnt_reg;
   logic [DLY_W-1:0] curDelay;
   logic thresholdMode;
   logic delayDone;

   // the modes that compare a value, as against fixed or serial control
   function automatic logic comparesValue(input trp_mode_t m);
      comparesValue = (m != MODE_INACTIVE) && (m != MODE_SERIAL);
   endfunction

   assign thresholdMode = comparesValue(relayCfg.mode);
   assign curDelay = pendTarget_reg ? relayCfg.assertDelay : relayCfg.releaseDelay;
   // the full delay at least: the first step after arming may come early
   assign delayDone = (dlyCnt_reg >= TIMER_W'(curDelay));

   // pending transition armed on a crossing, confirmed after the delay
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         relay_reg <= 1'b0;
         pending_reg <= 1'b0;
         pendTarget_reg <= 1'b0;
         dlyCnt_reg <= '0;
      end else if (relayCfg.mode == MODE_INACTIVE) begin
         relay_reg <= 1'b0;
         pending_reg <= 1'b0;
      end else if (relayCfg.mode == MODE_SERIAL) begin
         relay_reg <= relayCfg.serialRelayState;
         pending_reg <= 1'b0;
      end else if (inCritical) begin
         // a critical input overrides the zones and drops any pending change
         pending_reg <= 1'b0;
         if (relayCfg.criticalAction == CRIT_FORCE_ON) begin
            relay_reg <= 1'b1;
         end else if (relayCfg.criticalAction == CRIT_FORCE_OFF) begin
            relay_reg <= 1'b0;
         end
      end else if (thresholdMode && inValid && settled && (wantOn != relay_reg)) begin
         if (((wantOn ? relayCfg.assertDelay : relayCfg.releaseDelay) == DLY_W'(DLY_RESET))) begin
            relay_reg <= wantOn;
            pending_reg <= 1'b0;
         end else if (!pending_reg || pendTarget_reg != wantOn) begin
            pending_reg <= 1'b1;
            pendTarget_reg <= wantOn;
            dlyCnt_reg <= '0;
         end else if (delayStep) begin
            // a confirming sample on a step edge must not swallow that step
            if (delayDone) begin
               relay_reg <= pendTarget_reg;
               pending_reg <= 1'b0;
            end
            dlyCnt_reg <= dlyCnt_reg + 1'b1;
         end
      end else if (thresholdMode && inValid && pending_reg && !(settled && wantOn == pendTarget_reg)) begin
         // back inside the border or in the old zone: drop the pending change
         pending_reg <= 1'b0;
      end else if (pending_reg && delayStep) begin
         if (delayDone) begin
            relay_reg <= pendTarget_reg;
            pending_reg <= 1'b0;
         end
         dlyCnt_reg <= dlyCnt_reg + 1'b1;
      end
   end

   // ***********************************************
   // outputs
   // ***********************************************
   // contacts stay open when no relay is fitted; the logic behind runs the same
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         relayDrive <= 1'b0;
      end else begin
         relayDrive <= relay_reg && relayCfg.relayFitted;
      end
   end

   // the indicator mirrors the relay state, fitted or not, in every mode
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         indicatorLed <= 1'b0;
      end else begin
         indicatorLed <= relay_reg;
      end
   end

endmodule // trp_relay_ctrl

// >>> sim/trp_contact_model.sv
// partner model: relay contacts switching the controlled installation
`timescale 1ns/1ps
module trp_contact_model
   import trp_pkg::*;
(
   input logic core_clk,
   input logic reset_n,
   input logic relayDrive,
   output logic contactClosed
);
   // ********************
   // contacts
   // ********************
   logic contact_reg;
   // armature lags the coil one clock; real travel is far longer, not modelled
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         contact_reg <= 1'b0;
      end else begin
         contact_reg <= relayDrive;
      end
   end
   assign contactClosed = contact_reg;
endmodule // trp_contact_model

// >>> sim/trp_relay_ctrl_props.sv
// checker: properties on the relay controller ports
`timescale 1ns/1ps
module trp_relay_ctrl_props
   import trp_pkg::*;
(
   input logic core_clk,
   input logic reset_n,
   input logic signed [VAL_W-1:0] inValue,
   input logic inValid,
   input logic inCritical,
   input trp_peak_cfg_t peakCfg,
   input trp_relay_cfg_t relayCfg,
   input logic relayDrive,
   input logic indicatorLed,
   input logic signed [VAL_W-1:0] presentedValue,
   input logic peakHolding
);
   // ********************
   // helpers
   // ********************
   trp_mode_t md;
   logic calm;
   logic signed [VAL_W+1:0] upB;
   logic signed [VAL_W+1:0] lowB;
   // two spare bits so threshold plus hysteresis cannot wrap
   assign upB = relayCfg.firstThreshold + $signed({2'h0, relayCfg.hysteresisHalfWidth});
   assign lowB = relayCfg.firstThreshold - $signed({2'h0, relayCfg.hysteresisHalfWidth});
   assign md = relayCfg.mode;
   // zero delays, live value, fitted relay, no critical condition
   assign calm = relayCfg.assertDelay == '0 && relayCfg.releaseDelay == '0 && !relayCfg.usePeak
      && relayCfg.relayFitted && !inCritical;
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // ********************
   // properties
   // ********************
   // a decision taken at a strobe reaches the pins two edges later
   led_tracks_relay_a:
   assert property (relayCfg.relayFitted && $past(relayCfg.relayFitted) |-> relayDrive == indicatorLed)
      else $error("relay and led differ");
   unfitted_coil_off_a:
   assert property (!relayCfg.relayFitted && !$past(relayCfg.relayFitted) |-> !relayDrive)
      else $error("coil driven while unfitted");
   inactive_off_a:
   assert property ((inValid && md == MODE_INACTIVE && !inCritical) |-> ##2 !indicatorLed)
      else $error("inactive output closed");
   serial_follow_a:
   assert property ((inValid && md == MODE_SERIAL && !inCritical) |->
      ##2 indicatorLed == $past(relayCfg.serialRelayState, 2)) else $error("serial state not followed");
   crit_force_on_a:
   assert property ((inValid && inCritical && relayCfg.criticalAction == CRIT_FORCE_ON
      && md == MODE_ON_ABOVE) |-> ##2 indicatorLed) else $error("critical force on missed");
   crit_force_off_a:
   assert property ((inValid && inCritical && relayCfg.criticalAction == CRIT_FORCE_OFF
      && md == MODE_ON_ABOVE) |-> ##2 !indicatorLed) else $error("critical force off missed");
   above_closes_a:
   assert property ((inValid && calm && md == MODE_ON_ABOVE && inValue > upB) |-> ##2 indicatorLed)
      else $error("no close above border");
   below_opens_a:
   assert property ((inValid && calm && md == MODE_ON_ABOVE && inValue < lowB) |-> ##2 !indicatorLed)
      else $error("no open below border");
endmodule // trp_relay_ctrl_props
bind trp_relay_ctrl trp_relay_ctrl_props trp_relay_ctrl_props_i (.core_clk, .reset_n, .inValue, .inValid,
   .inCritical, .peakCfg, .relayCfg, .relayDrive, .indicatorLed, .presentedValue, .peakHolding);

// >>> sim/tb.sv
// testbench: self-checking scenarios for the relay controller
`timescale 1ns/1ps
module tb import trp_pkg::*;;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic signed [VAL_W-1:0] inValue = '0;
   logic inValid = 1'b0;
   logic inCritical = 1'b0;
   trp_peak_cfg_t peakCfg = '0;
   trp_relay_cfg_t relayCfg = '0;
   logic relayDrive, indicatorLed, peakHolding, contactClosed;
   logic signed [VAL_W-1:0] presentedValue;
   int numErrors = 0;
   int nChecks = 0;
   int cycleCount = 0;
   // ********************
   // clock, design, partner
   // ********************
   always #2.5 core_clk = ~core_clk;
   trp_relay_ctrl trp_relay_ctrl_i (.core_clk, .reset_n, .inValue, .inValid, .inCritical, .peakCfg,
      .relayCfg, .relayDrive, .indicatorLed, .presentedValue, .peakHolding);
   trp_contact_model trp_contact_model_i (.core_clk, .reset_n, .relayDrive, .contactClosed);
   // ********************
   // shared tasks
   // ********************
   task automatic report_and_stop();
      if (numErrors == 0 && nChecks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [VAL_W-1:0] e, input logic [VAL_W-1:0] g);
      nChecks++;
      if (g !== e) begin
         numErrors++;
         $display("wrong value %s expected %0h seen %0h", what, e, g);
      end
   endtask
   // one strobed sample; returns once its decision shows at the pins
   task automatic smp(input logic signed [VAL_W-1:0] v);
      @(negedge core_clk);
      inValue = v;
      inValid = 1'b1;
      @(negedge core_clk);
      inValid = 1'b0;
      @(negedge core_clk);
   endtask
   task automatic step(input logic signed [VAL_W-1:0] v, input logic e);
      smp(v);
      chk("indicatorLed", VAL_W'(e), VAL_W'(indicatorLed));
      chk("relayDrive", VAL_W'(e & relayCfg.relayFitted), VAL_W'(relayDrive));
   endtask
   // ********************
   // scenarios
   // ********************
   // run first: a fresh tracker has no stale maximum to fall from
   task automatic test_peak();
      relayCfg = '0;
      relayCfg.mode = MODE_ON_ABOVE;
      relayCfg.firstThreshold = 16'sh003C;
      relayCfg.hysteresisHalfWidth = 16'h0005;
      relayCfg.usePeak = 1'b1;
      relayCfg.relayFitted = 1'b1;
      peakCfg = {1'b1, 16'h0014, 16'h000A};
      smp(16'sh0000);
      smp(16'sh0032);
      smp(16'sh0023);
      chk("peakHolding", '0, VAL_W'(peakHolding));
      smp(16'sh0019);
      @(negedge core_clk);
      chk("peakHolding", 16'h0001, VAL_W'(peakHolding));
      chk("presentedValue", 16'h0032, presentedValue);
      smp(16'sh005A);
      smp(16'sh003C);
      @(negedge core_clk);
      chk("presentedValue", 16'h005A, presentedValue);
      step(16'sh0028, 1'b1);
      relayCfg.usePeak = 1'b0;
      step(16'sh0028, 1'b0);
   endtask
   task automatic test_single();
      relayCfg.firstThreshold = 16'sh0064;
      relayCfg.hysteresisHalfWidth = 16'h000A;
      step(16'sh0078, 1'b1);
      step(16'sh0069, 1'b1);
      step(16'sh006E, 1'b1);
      @(negedge core_clk);
      chk("contactClosed", 16'h0001, VAL_W'(contactClosed));
      step(16'sh0059, 1'b0);
      step(16'sh006E, 1'b0);
      relayCfg.mode = MODE_OFF_ABOVE;
      step(16'sh0078, 1'b0);
      step(16'sh0050, 1'b1);
   endtask
   task automatic test_band();
      relayCfg.mode = MODE_IN_BAND;
      relayCfg.firstThreshold = 16'sh00C8;
      relayCfg.secondThreshold = 16'sh0064;
      step(16'sh00FA, 1'b0);
      step(16'sh0096, 1'b1);
      step(16'sh0032, 1'b0);
      relayCfg.mode = MODE_OUT_BAND;
      step(16'sh0032, 1'b1);
      step(16'sh0096, 1'b0);
      step(16'sh00FA, 1'b1);
   endtask
   task automatic test_override();
      relayCfg.mode = MODE_INACTIVE;
      step(16'sh012C, 1'b0);
      relayCfg.mode = MODE_SERIAL;
      relayCfg.serialRelayState = 1'b1;
      step(16'shFFCE, 1'b1);
      relayCfg.serialRelayState = 1'b0;
      step(16'sh012C, 1'b0);
      relayCfg.mode = MODE_ON_ABOVE;
      relayCfg.firstThreshold = 16'sh0064;
      inCritical = 1'b1;
      relayCfg.criticalAction = CRIT_FORCE_ON;
      step(16'sh0000, 1'b1);
      relayCfg.criticalAction = CRIT_HOLD;
      step(16'sh0000, 1'b1);
      relayCfg.criticalAction = CRIT_FORCE_OFF;
      step(16'sh012C, 1'b0);
      inCritical = 1'b0;
      relayCfg.relayFitted = 1'b0;
      step(16'sh012C, 1'b1);
      peakCfg.peakEnable = 1'b0;
      smp(16'sh0010);
      chk("peakHolding", '0, VAL_W'(peakHolding));
      chk("presentedValue", 16'h0010, presentedValue);
   endtask
   // ********************
   // sequence and watchdog
   // ********************
   // a hang counts as a mismatch; the run needs under a hundred cycles
   always @(posedge core_clk) begin
      cycleCount <= cycleCount + 1;
      if (cycleCount == 5000) begin
         numErrors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (3) @(negedge core_clk);
      chk("indicatorLed", '0, VAL_W'(indicatorLed));
      chk("presentedValue", '0, presentedValue);
      reset_n = 1'b1;
      test_peak();
      test_single();
      test_band();
      test_override();
      report_and_stop();
   end
endmodule // tb
